// file: design/lps_pkg.sv
// Constants, types and frame helper shared by the primitive sequencer and its leaf modules.
// Assumes one clock domain. The peer-to-peer frame procedures sit outside this block.
package lps_pkg;

  // Width of one message unit carried by a data primitive.
  localparam int MU_W = 32;
  // Address (two octets) plus control (one octet) ahead of the message unit.
  localparam int HDR_W   = 24;
  localparam int FRAME_W = MU_W + HDR_W;

  // Queue depths; both must be powers of two.
  localparam int IND_DEPTH = 4;
  localparam int ACK_DEPTH = 4;

  // Field positions inside a frame word, most significant octet sent first.
  localparam int FR_SAPI_LSB = FRAME_W - 6;
  localparam int FR_CTRL_LSB = MU_W;

  // Address and control codes.
  localparam logic [5:0] SAPI_L3    = 6'h00;
  localparam logic [5:0] SAPI_MGMT  = 6'h3F;
  localparam logic [6:0] TEI_GROUP  = 7'h7F;
  localparam logic       CR_CMD     = 1'b0;
  localparam logic [7:0] CTRL_UI    = 8'h03;
  localparam logic [7:0] CTRL_I     = 8'h00;

  // Reset values of the endpoint state flops.
  localparam logic [1:0] P2P_RST = 2'h0;
  localparam logic       BC_RST  = 1'b0;

  // Generic names and primitive types as they cross the layer 3 boundary.
  typedef enum logic [1:0] {GEN_EST = 2'h0, GEN_REL = 2'h1, GEN_DATA = 2'h2, GEN_UDATA = 2'h3} lps_gen_t;
  typedef enum logic [1:0] {TYP_REQ = 2'h0, TYP_IND = 2'h1, TYP_RESP = 2'h2, TYP_CONF = 2'h3} lps_typ_t;

  // Point-to-point endpoint states, Gray coded around the usual cycle.
  typedef enum logic [1:0] {ST_REL = 2'h0, ST_AW_EST = 2'h1, ST_EST = 2'h3, ST_AW_REL = 2'h2} lps_p2p_t;

  // A broadcast endpoint has exactly one state.
  typedef enum logic {BC_INFO = 1'b0} lps_bc_t;

  // Wraps a message unit into a complete frame without reordering its bits.
  function automatic logic [FRAME_W-1:0] lps_mk_frame(input logic [5:0] sapi, input logic [6:0] tei,
                                                    input logic [7:0] ctrl, input logic [MU_W-1:0] mu);
    lps_mk_frame = {sapi, CR_CMD, 1'b0, tei, 1'b1, ctrl, mu};
  endfunction : lps_mk_frame

endpackage : lps_pkg

// file: design/lps_strm_if.sv
// Valid/ready stream carrier used between the sequencer and its queues.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface lps_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lps_strm_if

// file: design/lps_fifo.sv
// First-in first-out queue of flip-flops with a flush input.
// Assumes D is a power of two; flush wins over a push in the same cycle.
`timescale 1ns/1ps
module lps_fifo
  import lps_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  input  wire logic flush,
  output logic      room_r,
  // Streams
  lps_strm_if.snk   wr,
  lps_strm_if.src   rd
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  // Handshake decode.
  assign push     = wr.valid && wr.ready && !flush;
  assign pop      = rd.valid && rd.ready && !flush;
  assign wr.ready = (cnt_r != (AW+1)'(D));
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem[rp_r];
  assign cnt_nxt  = flush ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers and fill count; room_r promises space for at least one more push.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      room_r <= 1'b1;
    end else begin
      wp_r   <= flush ? '0 : wp_r + AW'(push);
      rp_r   <= flush ? '0 : rp_r + AW'(pop);
      cnt_r  <= cnt_nxt;
      room_r <= (cnt_nxt < (AW+1)'(D - 1));
    end
  end

  // Storage is written in place; entries need no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

endmodule : lps_fifo

// file: design/lps_prio_arb.sv
// Two-class fixed-order arbiter for frames contending for the physical layer.
// Assumes requests stay up until granted; the grant is combinational.
`timescale 1ns/1ps
module lps_prio_arb
  import lps_pkg::*;
#(
  parameter int N = 3,
  parameter int W = 8
) (
  // Requests
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] hi,
  input  wire logic [W-1:0] data [N],
  // Result
  output logic [N-1:0]      grant,
  output logic [W-1:0]      sel_data,
  output logic              sel_hi
);
  logic [N-1:0] hi_req;
  logic [N-1:0] cand;
  logic [W-1:0] part [N];

  // High class beats low class; inside a class the lowest index wins.
  assign hi_req = req & hi;
  assign cand   = (|hi_req) ? hi_req : req;
  assign grant  = cand & (~cand + N'(1));
  assign sel_hi = |hi_req;

  // Select the granted entry by an OR of masked words.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sel
      if (i == 0) begin : g_first
        assign part[i] = grant[i] ? data[i] : '0;
      end else begin : g_rest
        assign part[i] = part[i-1] | (grant[i] ? data[i] : '0);
      end
    end
  endgenerate
  assign sel_data = part[N-1];

endmodule : lps_prio_arb

// file: design/lps_seq.sv
// Primitive sequencer between layer 3, management and the physical layer.
// Assumes one clock; the frame procedures drive the lk_* events as one-cycle pulses.
`timescale 1ns/1ps
module lps_seq
  import lps_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Layer 3 requests
  input  wire logic             l3_req_valid,
  input  wire logic [1:0]       l3_req_gen,
  input  wire logic [MU_W-1:0]  l3_req_mu,
  output logic                  l3_req_ready,
  // Layer 3 indications and confirms
  output logic                  l3_ind_valid,
  output logic [1:0]            l3_ind_gen,
  output logic [1:0]            l3_ind_typ,
  output logic [MU_W-1:0]       l3_ind_mu,
  input  wire logic             l3_ind_ready,
  // Management unit data requests
  input  wire logic             mgmt_req_valid,
  input  wire logic [MU_W-1:0]  mgmt_req_mu,
  output logic                  mgmt_req_ready,
  // Frame procedure events and commands
  input  wire logic             lk_est_done,
  input  wire logic             lk_est_fail,
  input  wire logic             lk_rel_seen,
  input  wire logic             lk_reest_seen,
  input  wire logic             lk_dm_f0,
  output logic                  lk_evt_ready,
  output logic                  lk_est_start,
  output logic                  lk_rel_start,
  // Assigned endpoint identifier
  input  wire logic [6:0]       tei,
  // Physical layer transmit
  output logic                  phy_req_valid,
  output logic                  phy_req_prio,
  output logic [FRAME_W-1:0]    phy_req_frame,
  input  wire logic             phy_req_ready,
  // Physical layer receive
  input  wire logic             phy_ind_valid,
  input  wire logic [FRAME_W-1:0] phy_ind_frame,
  output logic                  phy_ind_ready,
  // Endpoint state
  output logic [1:0]            p2p_state,
  output logic                  bc_state
);
  localparam int IE_W = 4 + MU_W;

  lps_p2p_t         st_r, st_nxt;
  lps_bc_t          bc_r;
  logic             hold_v_r, hold_v_nxt, take, acc;
  lps_gen_t         hold_gen_r;
  logic [MU_W-1:0]  hold_mu_r;
  logic             ud_v_r, mg_v_r, rx_v_r, phy_v_r, out_v_r;
  logic [MU_W-1:0]  ud_mu_r, mg_mu_r;
  logic [FRAME_W-1:0] rx_fr_r;
  logic             req_est, req_rel, sm_go, sm_take;
  logic             sm_push, flush, est_go, rel_go;
  lps_gen_t         sm_gen;
  lps_typ_t         sm_typ;
  logic             ind_room, ack_room;
  logic             rx_ui, rx_mgmt, rx_keep, rx_drain, rx_acc;
  logic             phy_load, out_load;
  logic [2:0]       arb_req, arb_hi, arb_grant;
  logic [FRAME_W-1:0] arb_data [3];
  logic [FRAME_W-1:0] arb_sel;
  logic             arb_sel_hi;

  lps_strm_if #(.W(IE_W))  ind_wr ();
  lps_strm_if #(.W(IE_W))  ind_rd ();
  lps_strm_if #(.W(MU_W))  ack_wr ();
  lps_strm_if #(.W(MU_W))  ack_rd ();

  // Indications to layer 3 leave in the order they were raised.
  lps_fifo #(.W(IE_W), .D(IND_DEPTH)) u_ind_q (
    .clk    (clk),
    .nrst   (nrst),
    .flush  (1'b0),
    .room_r (ind_room),
    .wr     (ind_wr),
    .rd     (ind_rd)
  );

  // Acknowledged data waits here until the link is established.
  lps_fifo #(.W(MU_W), .D(ACK_DEPTH)) u_ack_q (
    .clk    (clk),
    .nrst   (nrst),
    .flush  (flush),
    .room_r (ack_room),
    .wr     (ack_wr),
    .rd     (ack_rd)
  );

  // Request decode; a held request is one primitive taken by one handshake.
  assign acc     = l3_req_valid && l3_req_ready;
  assign req_est = hold_v_r && (hold_gen_r == GEN_EST);
  assign req_rel = hold_v_r && (hold_gen_r == GEN_REL);
  assign sm_go   = (req_est || req_rel) && ind_room;
  assign take    = sm_take
                || (hold_v_r && (hold_gen_r == GEN_DATA) && ack_wr.ready)
                || (hold_v_r && (hold_gen_r == GEN_UDATA) && !ud_v_r);
  assign hold_v_nxt   = acc || (hold_v_r && !take);
  assign ack_wr.valid = hold_v_r && (hold_gen_r == GEN_DATA);
  assign ack_wr.data  = hold_mu_r;

  // Endpoint state machine; link events win over a held request in the same cycle.
  always_comb begin
    st_nxt  = st_r;
    sm_push = 1'b0;
    sm_gen  = GEN_EST;
    sm_typ  = TYP_IND;
    flush   = 1'b0;
    est_go  = 1'b0;
    rel_go  = 1'b0;
    sm_take = 1'b0;
    unique case (st_r)
      ST_REL: begin
        if (lk_reest_seen) begin
          st_nxt  = ST_EST;
          sm_push = 1'b1;
          flush   = 1'b1;
        end else if (lk_dm_f0) begin
          st_nxt = ST_AW_EST;
          est_go = 1'b1;
        end else if (sm_go) begin
          sm_take = 1'b1;
          if (req_est) begin
            st_nxt = ST_AW_EST;
            est_go = 1'b1;
          end else begin
            sm_push = 1'b1; // Immediate confirm: nothing to release.
            sm_gen  = GEN_REL;
            sm_typ  = TYP_CONF;
            flush   = 1'b1;
          end
        end
      end
      ST_AW_EST: begin
        if (lk_est_done || lk_reest_seen) begin
          st_nxt  = ST_EST;
          sm_push = 1'b1;
          sm_typ  = TYP_CONF;
        end else if (lk_est_fail) begin
          st_nxt  = ST_REL;
          sm_push = 1'b1;
          sm_gen  = GEN_REL;
          flush   = 1'b1;
        end else if (lk_rel_seen) begin
          sm_push = 1'b1;
          sm_gen  = GEN_REL;
          flush   = 1'b1;
          est_go  = 1'b1; // Unrelated release: keep establishing
        end else if (sm_go) begin
          sm_take = 1'b1;
          if (req_est) begin
            est_go = 1'b1;
          end else begin
            st_nxt = ST_AW_REL;
            rel_go = 1'b1;
          end
        end
      end
      ST_EST: begin
        if (lk_rel_seen) begin
          st_nxt  = ST_REL;
          sm_push = 1'b1;
          sm_gen  = GEN_REL;
          flush   = 1'b1;
        end else if (lk_reest_seen) begin
          sm_push = 1'b1;
          flush   = 1'b1;
        end else if (lk_dm_f0) begin
          st_nxt = ST_AW_EST;
          est_go = 1'b1;
        end else if (sm_go) begin
          sm_take = 1'b1;
          if (req_est) begin
            st_nxt = ST_AW_EST; // A confirm may still be queued; it is followed by another
            est_go = 1'b1;
          end else begin
            st_nxt = ST_AW_REL;
            rel_go = 1'b1;
          end
        end
      end
      ST_AW_REL: begin
        if (lk_rel_seen || lk_est_fail) begin
          st_nxt  = ST_REL;
          sm_push = 1'b1;
          sm_gen  = GEN_REL;
          sm_typ  = TYP_CONF;
          flush   = 1'b1;
        end else if (sm_go) begin
          sm_take = 1'b1;
          if (req_est) begin
            st_nxt = ST_AW_EST;
            est_go = 1'b1;
          end
        end
      end
    endcase
  end

  // Received frames: the information field alone goes up to layer 3.
  assign rx_ui    = (rx_fr_r[FR_CTRL_LSB +: 8] == CTRL_UI);
  assign rx_mgmt  = (rx_fr_r[FR_SAPI_LSB +: 6] == SAPI_MGMT);
  assign rx_keep  = !rx_mgmt && (rx_ui || (st_r == ST_EST));
  assign rx_drain = rx_v_r && !sm_push && (ind_wr.ready || !rx_keep);
  assign rx_acc   = phy_ind_valid && phy_ind_ready;
  assign ind_wr.valid = sm_push || (rx_v_r && rx_keep && !sm_push);
  assign ind_wr.data  = sm_push ? {sm_gen, sm_typ, {MU_W{1'b0}}}
                      : {(rx_ui ? GEN_UDATA : GEN_DATA), TYP_IND, rx_fr_r[MU_W-1:0]};

  // Physical transmit contenders: acknowledged data, unit data, management.
  assign phy_load    = !phy_v_r || phy_req_ready;
  assign arb_req     = {mg_v_r, ud_v_r, ack_rd.valid && (st_r == ST_EST)} & {3{phy_load}};
  assign arb_hi      = {SAPI_MGMT == 6'h00, SAPI_L3 == 6'h00, SAPI_L3 == 6'h00};
  assign arb_data[0] = lps_mk_frame(SAPI_L3, tei, CTRL_I, ack_rd.data);
  assign arb_data[1] = lps_mk_frame(SAPI_L3, TEI_GROUP, CTRL_UI, ud_mu_r);
  assign arb_data[2] = lps_mk_frame(SAPI_MGMT, TEI_GROUP, CTRL_UI, mg_mu_r);
  assign ack_rd.ready = arb_grant[0];

  lps_prio_arb #(.N(3), .W(FRAME_W)) u_arb (
    .req      (arb_req),
    .hi       (arb_hi),
    .data     (arb_data),
    .grant    (arb_grant),
    .sel_data (arb_sel),
    .sel_hi   (arb_sel_hi)
  );

  // Indication output stage refills whenever layer 3 takes the current one.
  assign out_load     = !out_v_r || l3_ind_ready;
  assign ind_rd.ready = out_load;

  // Endpoint states, held request and command pulses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r         <= lps_p2p_t'(P2P_RST);
      bc_r         <= lps_bc_t'(BC_RST);
      hold_v_r     <= 1'b0;
      hold_gen_r   <= GEN_EST;
      hold_mu_r    <= '0;
      l3_req_ready <= 1'b1;
      lk_est_start <= 1'b0;
      lk_rel_start <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      bc_r         <= BC_INFO;
      hold_v_r     <= hold_v_nxt;
      l3_req_ready <= !hold_v_nxt;
      lk_est_start <= est_go;
      lk_rel_start <= rel_go;
      if (acc) begin
        hold_gen_r <= lps_gen_t'(l3_req_gen);
        hold_mu_r  <= l3_req_mu;
      end
    end
  end

  // Single-entry slots for unit data, management data and received frames.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ud_v_r         <= 1'b0;
      ud_mu_r        <= '0;
      mg_v_r         <= 1'b0;
      mg_mu_r        <= '0;
      mgmt_req_ready <= 1'b1;
      rx_v_r         <= 1'b0;
      rx_fr_r        <= '0;
      phy_ind_ready  <= 1'b1;
    end else begin
      if (hold_v_r && (hold_gen_r == GEN_UDATA) && !ud_v_r) begin
        ud_v_r  <= 1'b1;
        ud_mu_r <= hold_mu_r;
      end else if (arb_grant[1]) begin
        ud_v_r <= 1'b0;
      end
      if (mgmt_req_valid && mgmt_req_ready) begin
        mg_v_r         <= 1'b1;
        mg_mu_r        <= mgmt_req_mu;
        mgmt_req_ready <= 1'b0;
      end else if (arb_grant[2]) begin
        mg_v_r         <= 1'b0;
        mgmt_req_ready <= 1'b1;
      end
      if (rx_acc) begin
        rx_v_r        <= 1'b1;
        rx_fr_r       <= phy_ind_frame;
        phy_ind_ready <= 1'b0;
      end else if (rx_drain) begin
        rx_v_r        <= 1'b0;
        phy_ind_ready <= 1'b1;
      end
    end
  end

  // Registered physical request and layer 3 indication outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phy_v_r       <= 1'b0;
      phy_req_prio  <= 1'b0;
      phy_req_frame <= '0;
      out_v_r       <= 1'b0;
      l3_ind_gen    <= '0;
      l3_ind_typ    <= '0;
      l3_ind_mu     <= '0;
    end else begin
      if (phy_load) begin
        phy_v_r <= |arb_grant;
        if (|arb_grant) begin
          phy_req_prio  <= arb_sel_hi;
          phy_req_frame <= arb_sel;
        end
      end
      if (out_load) begin
        out_v_r <= ind_rd.valid;
        if (ind_rd.valid) begin
          l3_ind_gen <= ind_rd.data[IE_W-1 -: 2];
          l3_ind_typ <= ind_rd.data[IE_W-3 -: 2];
          l3_ind_mu  <= ind_rd.data[MU_W-1:0];
        end
      end
    end
  end

  // Output wiring from the flops above.
  assign phy_req_valid = phy_v_r;
  assign l3_ind_valid  = out_v_r;
  assign lk_evt_ready  = ind_room;
  assign p2p_state     = st_r;
  assign bc_state      = bc_r;

endmodule : lps_seq

// file: bench/lps_seq_checker.sv
// Concurrent checks on the ports of the primitive sequencer.
// Assumes one clock domain; bound to every lps_seq instance.
`timescale 1ns/1ps
module lps_seq_checker
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Layer 3 side
  input wire logic               l3_req_valid,
  input wire logic               l3_req_ready,
  input wire logic               l3_ind_valid,
  input wire logic [1:0]         l3_ind_gen,
  input wire logic [1:0]         l3_ind_typ,
  input wire logic [MU_W-1:0]    l3_ind_mu,
  input wire logic               l3_ind_ready,
  // Link and physical side
  input wire logic               lk_est_start,
  input wire logic [6:0]         tei,
  input wire logic               phy_req_valid,
  input wire logic               phy_req_prio,
  input wire logic [FRAME_W-1:0] phy_req_frame,
  input wire logic               phy_req_ready,
  // Endpoint state
  input wire logic [1:0]         p2p_state,
  input wire logic               bc_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Header fields of the frame on offer.
  wire logic [5:0] fr_sapi = phy_req_frame[FR_SAPI_LSB +: 6];
  wire logic [7:0] fr_ctrl = phy_req_frame[FR_CTRL_LSB +: 8];
  wire logic [6:0] fr_tei  = phy_req_frame[FR_CTRL_LSB+9 +: 7];

  a_bc_state_fixed: assert property (bc_state == BC_INFO)
    else $error("broadcast endpoint left information transfer");
  a_prio_class: assert property (phy_req_valid |-> phy_req_prio == (fr_sapi == SAPI_L3))
    else $error("priority flag does not match access point");
  a_tx_frame_hold: assert property (phy_req_valid && !phy_req_ready |=>
    phy_req_valid && $stable(phy_req_frame)) else $error("frame changed before taken");
  a_ind_hold: assert property (l3_ind_valid && !l3_ind_ready |=>
    l3_ind_valid && $stable({l3_ind_gen, l3_ind_typ, l3_ind_mu})) else $error("primitive changed before taken");
  a_req_ready_drop: assert property (l3_req_valid && l3_req_ready |=> !l3_req_ready)
    else $error("request slot still open after accept");
  a_ack_frame_hdr: assert property (phy_req_valid && fr_ctrl == CTRL_I |-> fr_tei == tei &&
    phy_req_frame[FR_CTRL_LSB+8] && !phy_req_frame[FR_CTRL_LSB+16]) else $error("bad acknowledged header");
  a_ack_in_est: assert property ($rose(phy_req_valid) && fr_ctrl == CTRL_I |->
    p2p_state == ST_EST || $past(p2p_state) == ST_EST) else $error("acknowledged frame outside established");
  a_est_start_state: assert property (lk_est_start |-> p2p_state == ST_AW_EST)
    else $error("establishment started outside awaiting establish");

  c_est_conf: cover property (l3_ind_valid && l3_ind_ready && l3_ind_gen == GEN_EST && l3_ind_typ == TYP_CONF);
  c_rel_ind: cover property (l3_ind_valid && l3_ind_gen == GEN_REL && l3_ind_typ == TYP_IND);
  c_tx_stall: cover property (phy_req_valid && !phy_req_ready ##1 phy_req_ready);
endmodule : lps_seq_checker

bind lps_seq lps_seq_checker u_chk (.clk(clk), .nrst(nrst), .l3_req_valid(l3_req_valid),
  .l3_req_ready(l3_req_ready), .l3_ind_valid(l3_ind_valid), .l3_ind_gen(l3_ind_gen), .l3_ind_typ(l3_ind_typ),
  .l3_ind_mu(l3_ind_mu), .l3_ind_ready(l3_ind_ready), .lk_est_start(lk_est_start), .tei(tei),
  .phy_req_valid(phy_req_valid), .phy_req_prio(phy_req_prio), .phy_req_frame(phy_req_frame),
  .phy_req_ready(phy_req_ready), .p2p_state(p2p_state), .bc_state(bc_state));

// file: bench/lps_phy_model.sv
// Physical layer transmit side: takes frames promptly, slowly or not at all.
// Assumes the sequencer holds each frame until it is taken.
`timescale 1ns/1ps
module lps_phy_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pace set by the bench
  input  wire logic hold,
  input  wire logic slow,
  // Transmit handshake
  input  wire logic valid,
  output logic      ready
);
  logic [1:0] cyc_r;

  // Ready moves after the falling edge so it is settled at the sampling edge.
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      cyc_r <= 2'h0;
      ready <= 1'b0;
    end else begin
      cyc_r <= cyc_r + 2'h1;
      ready <= !hold && (!slow || cyc_r == 2'h3);
    end
  end
endmodule : lps_phy_model

// file: bench/testbench.sv
// Self-checking bench for the primitive sequencer against a queue model.
// Assumes the bound checker and the physical layer model beside it.
`timescale 1ns/1ps
module testbench
  import lps_pkg::*;
;
  localparam logic [6:0] OWN_TEI = 7'h15;
  logic clk = 1'b0, nrst = 1'b0, hold = 1'b0, slow = 1'b0, ind_hold = 1'b0;
  logic l3_req_valid = 1'b0, l3_ind_ready = 1'b0, mgmt_req_valid = 1'b0, phy_ind_valid = 1'b0;
  logic [1:0] l3_req_gen = 2'h0;
  logic [MU_W-1:0] l3_req_mu = '0, mgmt_req_mu = '0, m [3];
  logic [4:0] lk_v = 5'h00;
  logic [FRAME_W-1:0] phy_ind_frame = '0;
  wire logic l3_req_ready, l3_ind_valid, mgmt_req_ready, lk_evt_ready, lk_est_start, lk_rel_start;
  wire logic phy_req_valid, phy_req_prio, phy_req_ready, phy_ind_ready, bc_state;
  wire logic [1:0] l3_ind_gen, l3_ind_typ, p2p_state;
  wire logic [MU_W-1:0] l3_ind_mu;
  wire logic [FRAME_W-1:0] phy_req_frame;
  logic [63:0] exp_q[$], got_q[$], etx_q[$], tx_q[$];
  int err_count = 0, checks = 0, est_cnt = 0, exp_est = 0, rel_cnt = 0;

  always #5 clk = ~clk;

  lps_seq dut (.clk(clk), .nrst(nrst), .l3_req_valid(l3_req_valid), .l3_req_gen(l3_req_gen),
    .l3_req_mu(l3_req_mu), .l3_req_ready(l3_req_ready), .l3_ind_valid(l3_ind_valid), .l3_ind_gen(l3_ind_gen),
    .l3_ind_typ(l3_ind_typ), .l3_ind_mu(l3_ind_mu), .l3_ind_ready(l3_ind_ready),
    .mgmt_req_valid(mgmt_req_valid), .mgmt_req_mu(mgmt_req_mu), .mgmt_req_ready(mgmt_req_ready),
    .lk_est_done(lk_v[0]), .lk_est_fail(lk_v[1]), .lk_rel_seen(lk_v[2]), .lk_reest_seen(lk_v[3]),
    .lk_dm_f0(lk_v[4]), .lk_evt_ready(lk_evt_ready), .lk_est_start(lk_est_start), .lk_rel_start(lk_rel_start),
    .tei(OWN_TEI), .phy_req_valid(phy_req_valid), .phy_req_prio(phy_req_prio), .phy_req_frame(phy_req_frame),
    .phy_req_ready(phy_req_ready), .phy_ind_valid(phy_ind_valid), .phy_ind_frame(phy_ind_frame),
    .phy_ind_ready(phy_ind_ready), .p2p_state(p2p_state), .bc_state(bc_state));

  lps_phy_model u_phy (.clk(clk), .nrst(nrst), .hold(hold), .slow(slow), .valid(phy_req_valid),
    .ready(phy_req_ready));

  // Layer 3 takes primitives at random moments unless told to stall.
  always @(negedge clk) l3_ind_ready <= !ind_hold && ($urandom % 4 != 0);

  // Record primitives, frames and link starts at the sampling edge.
  always @(posedge clk) begin
    if (nrst && l3_ind_valid && l3_ind_ready) got_q.push_back({28'h0, l3_ind_gen, l3_ind_typ, l3_ind_mu});
    if (nrst && phy_req_valid && phy_req_ready) tx_q.push_back({8'h00, phy_req_frame});
    if (nrst && lk_est_start) est_cnt++;
    if (nrst && lk_rel_start) rel_cnt++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [63:0] ind(input logic [1:0] g, input logic [1:0] t, input logic [MU_W-1:0] mu);
    return {28'h0, g, t, mu};
  endfunction : ind

  function automatic logic [63:0] frm(input logic [5:0] s, input logic [6:0] t, input logic [7:0] c,
                                      input logic [MU_W-1:0] mu);
    return {8'h00, s, 2'h0, t, 1'b1, c, mu};
  endfunction : frm

  // One request from layer 3 or management, held until the slot takes it.
  task automatic req(input bit mg, input logic [1:0] gen, input logic [MU_W-1:0] mu);
    @(negedge clk);
    l3_req_valid = !mg;
    mgmt_req_valid = mg;
    l3_req_gen = gen;
    l3_req_mu = mu;
    mgmt_req_mu = mu;
    @(posedge clk);
    while (!(mg ? mgmt_req_ready : l3_req_ready)) @(posedge clk);
    @(negedge clk);
    l3_req_valid = 1'b0;
    mgmt_req_valid = 1'b0;
    l3_req_mu = ~mu;
    mgmt_req_mu = ~mu;
  endtask : req

  // One-cycle link event, given only while events are accepted.
  task automatic lk(input int i);
    @(negedge clk);
    while (!lk_evt_ready) @(negedge clk);
    lk_v[i] = 1'b1;
    @(negedge clk);
    lk_v = 5'h00;
  endtask : lk

  // One received frame; group identifier on unit data, own one otherwise.
  task automatic rx(input logic [5:0] s, input logic [7:0] c, input logic [MU_W-1:0] mu);
    @(negedge clk);
    phy_ind_valid = 1'b1;
    phy_ind_frame = {s, 2'h0, (c == CTRL_UI) ? TEI_GROUP : OWN_TEI, 1'b1, c, mu};
    @(posedge clk);
    while (!phy_ind_ready) @(posedge clk);
    @(negedge clk);
    phy_ind_valid = 1'b0;
    phy_ind_frame = ~phy_ind_frame;
  endtask : rx

  task automatic wait_est();
    for (int n = 0; n < 50 && est_cnt != exp_est; n++) @(posedge clk);
  endtask : wait_est

  // Waits for the traffic, then compares it in order with the model.
  task automatic sync(input string name);
    for (int n = 0; n < 400 && (got_q.size() < exp_q.size() || tx_q.size() < etx_q.size()); n++) @(posedge clk);
    repeat (8) @(posedge clk);
    check(est_cnt, exp_est);
    check(got_q.size(), exp_q.size());
    check(tx_q.size(), etx_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    while (etx_q.size() > 0 && tx_q.size() > 0) check(tx_q.pop_front(), etx_q.pop_front());
    exp_q.delete();
    got_q.delete();
    etx_q.delete();
    tx_q.delete();
    $display("test %s done", name);
  endtask : sync

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Cuts a hang short at 20000 cycles; the tests need fewer than 1000 cycles.
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h656B1222));
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    check({p2p_state, bc_state, l3_req_ready, mgmt_req_ready, phy_ind_ready, lk_evt_ready}, 7'h0F);
    foreach (m[i]) m[i] = $urandom();
    req(0, GEN_REL, m[0]);
    exp_q.push_back(ind(GEN_REL, TYP_CONF, 32'h0));
    req(0, GEN_EST, m[1]);
    exp_est++;
    wait_est();
    lk(0);
    exp_q.push_back(ind(GEN_EST, TYP_CONF, 32'h0));
    sync("establish");
    check(p2p_state, ST_EST);
    hold = 1'b1;
    req(0, GEN_DATA, m[0]);
    req(0, GEN_UDATA, m[2]);
    req(1, 2'h0, m[1]);
    slow = 1'b1;
    hold = 1'b0;
    etx_q.push_back(frm(SAPI_L3, OWN_TEI, CTRL_I, m[0]));
    etx_q.push_back(frm(SAPI_L3, TEI_GROUP, CTRL_UI, m[2]));
    etx_q.push_back(frm(SAPI_MGMT, TEI_GROUP, CTRL_UI, m[1]));
    sync("priority");
    slow = 1'b0;
    rx(SAPI_L3, CTRL_UI, m[0]);
    rx(SAPI_L3, CTRL_I, m[1]);
    rx(SAPI_MGMT, CTRL_UI, m[2]);
    lk(3);
    exp_q.push_back(ind(GEN_UDATA, TYP_IND, m[0]));
    exp_q.push_back(ind(GEN_DATA, TYP_IND, m[1]));
    exp_q.push_back(ind(GEN_EST, TYP_IND, 32'h0));
    sync("receive");
    hold = 1'b1;
    repeat (3) req(0, GEN_DATA, $urandom());
    lk(2);
    exp_q.push_back(ind(GEN_REL, TYP_IND, 32'h0));
    hold = 1'b0;
    repeat (20) @(posedge clk);
    check(tx_q.size() <= 1, 1'b1);
    tx_q.delete();
    sync("flush");
    req(0, GEN_EST, m[0]);
    exp_est++;
    wait_est();
    ind_hold = 1'b1;
    lk(2);
    exp_q.push_back(ind(GEN_REL, TYP_IND, 32'h0));
    exp_est++;
    wait_est();
    lk(0);
    req(0, GEN_EST, m[1]);
    exp_est++;
    wait_est();
    lk(0);
    ind_hold = 1'b0;
    repeat (2) exp_q.push_back(ind(GEN_EST, TYP_CONF, 32'h0));
    sync("crossing");
    req(0, GEN_EST, m[2]);
    exp_est++;
    wait_est();
    lk(1);
    exp_q.push_back(ind(GEN_REL, TYP_IND, 32'h0));
    sync("failed establish");
    check(p2p_state, ST_REL);
    lk(4);
    exp_est++;
    wait_est();
    lk(0);
    exp_q.push_back(ind(GEN_EST, TYP_CONF, 32'h0));
    sync("unsolicited release");
    check(p2p_state, ST_EST);
    req(0, GEN_REL, m[0]);
    lk(2);
    exp_q.push_back(ind(GEN_REL, TYP_CONF, 32'h0));
    sync("release");
    check(rel_cnt, 1);
    print_verdict();
  end
endmodule : testbench
